//--- logic/sfb_pkg.sv
// package: stack frame builder constants and carriers
package sfb_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned LEVEL_W     = 5;
  localparam int unsigned STORAGE_W   = 16;
  localparam logic [31:0] PTR_STEP    = 32'h0000_0004;
  localparam logic [4:0]  LEVEL_MAX   = 5'h1F;
  localparam logic [31:0] SP_RESET    = 32'h0000_0000;
  localparam logic [31:0] FB_RESET    = 32'h0000_0000;
  localparam logic [1:0]  SEG_DATA    = 2'h0;
  localparam logic [1:0]  SEG_STACK   = 2'h1;

  typedef enum logic [1:0] {
    SFB_OP_NONE  = 2'h0,
    SFB_OP_ENTER = 2'h1,
    SFB_OP_LEAVE = 2'h2
  } sfb_op_type;

  typedef struct packed {
    sfb_op_type     op;
    logic [15:0]    storage;
    logic [4:0]     level;
  } sfb_cmd_type;

  typedef struct packed {
    logic           valid;
    logic           write;
    logic [31:0]    addr;
    logic [31:0]    wdata;
  } sfb_mem_req_type;
endpackage

//--- logic/sfb_mem_port.sv
// module: one outstanding stack memory access
`timescale 1ns/1ps
`default_nettype none
module sfb_mem_port (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // from sequencer
  input  wire logic                     start,
  input  wire logic                     start_write,
  input  wire logic [31:0]              start_addr,
  input  wire logic [31:0]              start_wdata,
  output logic                          done,
  output logic [31:0]                   done_rdata,
  // to stack memory
  output sfb_pkg::sfb_mem_req_type      mem_req,
  input  wire logic                     mem_ack,
  input  wire logic [31:0]              mem_rdata
);
  sfb_pkg::sfb_mem_req_type req_reg, req_next;
  logic                     done_reg, done_next;
  logic [31:0]              rdata_reg, rdata_next;

  always_comb begin
    req_next   = req_reg;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    if (req_reg.valid && mem_ack) begin
      req_next.valid = 1'b0;
      done_next      = 1'b1;
      rdata_next     = mem_rdata;
    end else if (!req_reg.valid && start) begin
      req_next.valid = 1'b1;
      req_next.write = start_write;
      req_next.addr  = start_addr;
      req_next.wdata = start_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_reg   <= '0;
      done_reg  <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      req_reg   <= req_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  assign mem_req    = req_reg;
  assign done       = done_reg;
  assign done_rdata = rdata_reg;
endmodule
`default_nettype wire

//--- logic/sfb_frame_builder.sv
// module: procedure entry and release sequencer
// What this block does
// - enter takes a local storage byte count and a nesting level
// - nesting level accepted from zero through thirty-one
// - level sets how many frame pointers copy into the new display
// - every frame pointer handled is one doubleword wide
// - first display doubleword holds the previous frame pointer
// - after the display, stack pointer drops by the storage byte count
// - frame base ends on the first, highest-addressed display doubleword
// - accesses based on the frame base default to the stack segment
// - level zero: push base, base takes stack pointer, subtract storage
// - nonzero level: push base, latch top, copy level-1 pointers
// - nonzero level: push saved top, base from it, subtract storage
// - level one copies no earlier pointers, pushes saved top, then reserves storage
// - level never checked against privilege or io privilege level
// - release: stack pointer takes base, then pop old base
`timescale 1ns/1ps
`default_nettype none
module sfb_frame_builder (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // command port
  input  wire logic                     cmd_valid,
  input  wire sfb_pkg::sfb_cmd_type     cmd,
  output logic                          cmd_ready,
  output logic                          cmd_done,
  // register load port
  input  wire logic                     load_en,
  input  wire logic [31:0]              load_sp,
  input  wire logic [31:0]              load_fb,
  output logic [31:0]                   stack_pointer_reg,
  output logic [31:0]                   frame_base_pointer,
  // segment default for base-register addressing
  input  wire logic                     base_is_fb,
  output logic [1:0]                    default_seg,
  // stack memory
  output sfb_pkg::sfb_mem_req_type      mem_req,
  input  wire logic                     mem_ack,
  input  wire logic [31:0]              mem_rdata
);
  typedef enum logic [2:0] {
    SFB_IDLE  = 3'h0,
    SFB_PUSH  = 3'h1,
    SFB_READ  = 3'h2,
    SFB_WAIT  = 3'h3,
    SFB_POPRD = 3'h4,
    SFB_DONE  = 3'h5
  } sfb_state_type;

  typedef enum logic [1:0] {
    SFB_PH_BASE = 2'h0,
    SFB_PH_COPY = 2'h1,
    SFB_PH_TOP  = 2'h2
  } sfb_phase_type;

  function automatic logic [31:0] sfb_dec4(input logic [31:0] v);
    sfb_dec4 = v - sfb_pkg::PTR_STEP;
  endfunction

  function automatic logic [31:0] sfb_alloc(input logic [31:0] v, input logic [15:0] n_bytes);
    sfb_alloc = v - {16'h0000, n_bytes};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  sfb_state_type  state_reg, state_next;
  sfb_phase_type  phase_reg, phase_next;
  logic [31:0]    sp_reg, sp_next;
  logic [31:0]    fb_reg, fb_next;
  logic [31:0]    top_reg, top_next;
  logic [15:0]    stor_reg, stor_next;
  logic [4:0]     cnt_reg, cnt_next;
  logic           done_reg, done_next;
  logic [1:0]     seg_reg, seg_next;

  logic           mp_start;
  logic           mp_write;
  logic [31:0]    mp_addr;
  logic [31:0]    mp_wdata;
  logic           mp_done;
  logic [31:0]    mp_rdata;

  sfb_mem_port u_port (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .start       (mp_start),
    .start_write (mp_write),
    .start_addr  (mp_addr),
    .start_wdata (mp_wdata),
    .done        (mp_done),
    .done_rdata  (mp_rdata),
    .mem_req     (mem_req),
    .mem_ack     (mem_ack),
    .mem_rdata   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // command and access decode

  logic           cmd_ok;
  logic           take_enter;
  logic           take_leave;
  logic           wr_done;
  logic           rd_done;
  logic           ready_reg, ready_next;

  assign cmd_ok     = ready_reg && cmd_valid && !load_en;
  assign take_enter = cmd_ok && (cmd.op == sfb_pkg::SFB_OP_ENTER);
  assign take_leave = cmd_ok && (cmd.op == sfb_pkg::SFB_OP_LEAVE);
  assign wr_done    = mp_done && mem_req.write;
  assign rd_done    = mp_done && !mem_req.write;

  ////////////////////////////////////////////////////////////////////////
  // sequence control

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    stor_next  = stor_reg;
    case (state_reg)
      SFB_IDLE: begin
        if (take_enter) begin
          // level is taken as given; no privilege comparison
          stor_next  = cmd.storage;
          cnt_next   = cmd.level & sfb_pkg::LEVEL_MAX;
          phase_next = SFB_PH_BASE;
          state_next = SFB_PUSH;
        end else if (take_leave) begin
          phase_next = SFB_PH_TOP;
          state_next = SFB_POPRD;
        end
      end
      SFB_PUSH:  state_next = SFB_WAIT;
      SFB_READ:  state_next = SFB_WAIT;
      SFB_POPRD: state_next = SFB_WAIT;
      SFB_WAIT: begin
        if (wr_done) begin
          case (phase_reg)
            SFB_PH_BASE: begin
              if (cnt_reg == 5'h00) begin
                state_next = SFB_DONE;
              end else if (cnt_reg == 5'h01) begin
                phase_next = SFB_PH_TOP;
                state_next = SFB_PUSH;
              end else begin
                cnt_next   = cnt_reg - 5'h01;
                phase_next = SFB_PH_COPY;
                state_next = SFB_READ;
              end
            end
            SFB_PH_COPY: begin
              if (cnt_reg == 5'h01) begin
                phase_next = SFB_PH_TOP;
                state_next = SFB_PUSH;
              end else begin
                cnt_next   = cnt_reg - 5'h01;
                state_next = SFB_READ;
              end
            end
            default: state_next = SFB_DONE;
          endcase
        end else if (rd_done) begin
          if (phase_reg == SFB_PH_COPY) begin
            state_next = SFB_PUSH;
          end else begin
            state_next = SFB_DONE;
          end
        end
      end
      SFB_DONE: state_next = SFB_IDLE;
      default:  state_next = SFB_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SFB_IDLE;
      phase_reg <= SFB_PH_BASE;
      cnt_reg   <= 5'h00;
      stor_reg  <= 16'h0000;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      stor_reg  <= stor_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack and frame pointers

  always_comb begin
    sp_next  = sp_reg;
    fb_next  = fb_reg;
    top_next = top_reg;
    case (state_reg)
      SFB_IDLE: begin
        if (load_en) begin
          sp_next = load_sp;
          fb_next = load_fb;
        end else if (take_leave) begin
          sp_next = fb_reg;
        end
      end
      SFB_WAIT: begin
        if (wr_done) begin
          sp_next = mem_req.addr;
          case (phase_reg)
            SFB_PH_BASE: begin
              top_next = mem_req.addr;
              if (cnt_reg == 5'h00) begin
                fb_next = mem_req.addr;
                sp_next = sfb_alloc(mem_req.addr, stor_reg);
              end else if (cnt_reg != 5'h01) begin
                fb_next = sfb_dec4(fb_reg);
              end
            end
            SFB_PH_COPY: begin
              if (cnt_reg != 5'h01) begin
                fb_next = sfb_dec4(fb_reg);
              end
            end
            default: begin
              fb_next = top_reg;
              sp_next = sfb_alloc(mem_req.addr, stor_reg);
            end
          endcase
        end else if (rd_done && phase_reg != SFB_PH_COPY) begin
          fb_next = mp_rdata;
          sp_next = sp_reg + sfb_pkg::PTR_STEP;
        end
      end
      default: sp_next = sp_reg;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sp_reg  <= sfb_pkg::SP_RESET;
      fb_reg  <= sfb_pkg::FB_RESET;
      top_reg <= 32'h0000_0000;
    end else begin
      sp_reg  <= sp_next;
      fb_reg  <= fb_next;
      top_reg <= top_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access launch

  always_comb begin
    mp_start = 1'b0;
    mp_write = 1'b0;
    mp_addr  = 32'h0000_0000;
    mp_wdata = 32'h0000_0000;
    case (state_reg)
      SFB_PUSH: begin
        mp_start = 1'b1;
        mp_write = 1'b1;
        mp_addr  = sfb_dec4(sp_reg);
        case (phase_reg)
          SFB_PH_BASE: mp_wdata = fb_reg;
          SFB_PH_COPY: mp_wdata = mp_rdata;
          default:     mp_wdata = top_reg;
        endcase
      end
      SFB_READ: begin
        mp_start = 1'b1;
        mp_addr  = fb_reg;
      end
      SFB_POPRD: begin
        mp_start = 1'b1;
        mp_addr  = sp_reg;
      end
      default: mp_start = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // status outputs

  always_comb begin
    done_next  = (state_reg == SFB_DONE);
    seg_next   = base_is_fb ? sfb_pkg::SEG_STACK : sfb_pkg::SEG_DATA;
    ready_next = (state_next == SFB_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      done_reg  <= 1'b0;
      seg_reg   <= sfb_pkg::SEG_DATA;
      ready_reg <= 1'b1;
    end else begin
      done_reg  <= done_next;
      seg_reg   <= seg_next;
      ready_reg <= ready_next;
    end
  end

  assign cmd_ready          = ready_reg;
  assign cmd_done           = done_reg;
  assign stack_pointer_reg  = sp_reg;
  assign frame_base_pointer = fb_reg;
  assign default_seg        = seg_reg;
endmodule
`default_nettype wire

//--- dv/sfb_stack_mem.sv
// stack memory partner model
`timescale 1ns/1ps
`default_nettype none
module sfb_stack_mem (
  // clock, reset and answer delay
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  input  wire logic [1:0]               dly,
  // memory port
  input  wire sfb_pkg::sfb_mem_req_type req,
  output logic                          ack,
  output logic [31:0]                   rdata
);
  logic [31:0] mem [256];
  logic [1:0]  cnt;
  logic [31:0] last;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'hA500_0000 | 32'(i);
  assign ack = req.valid && (cnt == dly);
  // idle read data shows the inverse of the last value
  assign rdata = ack ? mem[req.addr[9:2]] : ~last;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 2'h0;
      last <= 32'h0;
    end else if (ack) begin
      cnt <= 2'h0;
      last <= rdata;
      if (req.write) mem[req.addr[9:2]] <= req.wdata;
    end else if (req.valid) cnt <= cnt + 2'h1;
  end
endmodule
`default_nettype wire

//--- dv/sfb_frame_builder_assertions.sv
// port assertions for the frame builder
`timescale 1ns/1ps
`default_nettype none
module sfb_frame_builder_assertions (
  // watched ports
  input wire logic                     ref_clk,
  input wire logic                     rstn,
  input wire logic                     cmd_valid,
  input wire sfb_pkg::sfb_cmd_type     cmd,
  input wire logic                     cmd_ready,
  input wire logic                     cmd_done,
  input wire logic                     load_en,
  input wire logic [31:0]              frame_base_pointer,
  input wire logic                     base_is_fb,
  input wire logic [1:0]               default_seg,
  input wire sfb_pkg::sfb_mem_req_type mem_req,
  input wire logic                     mem_ack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic take;
  assign take = cmd_valid && cmd_ready && !load_en && cmd.op == sfb_pkg::SFB_OP_ENTER;
  sequence s_first_push;
    mem_req.valid && mem_req.write && mem_req.wdata == frame_base_pointer;
  endsequence
  a_req_hold: assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
    else $error("memory request changed before ack");
  a_seg_stack: assert property (base_is_fb |=> default_seg == sfb_pkg::SEG_STACK)
    else $error("frame base access not on stack segment");
  a_seg_data: assert property (!base_is_fb |=> default_seg == sfb_pkg::SEG_DATA)
    else $error("other access not on data segment");
  a_busy_ready: assert property (mem_req.valid |-> !cmd_ready)
    else $error("ready while memory access open");
  a_done_idle: assert property (cmd_done |-> !mem_req.valid ##1 !cmd_done)
    else $error("done not a lone pulse");
  a_first_push: assert property (take |-> ##[1:40] s_first_push)
    else $error("first push is not the old frame base");
  a_enter_bound: assert property (take |-> ##[1:1000] cmd_done)
    else $error("enter never completed");
  a_level_taken: assert property (take |=> !cmd_ready)
    else $error("enter not taken");
endmodule
bind sfb_frame_builder sfb_frame_builder_assertions u_chk (
  .ref_clk, .rstn, .cmd_valid, .cmd, .cmd_ready, .cmd_done, .frame_base_pointer,
  .load_en, .base_is_fb, .default_seg, .mem_req, .mem_ack
);
`default_nettype wire

//--- dv/tb_stack_frame_builder.sv
// self-checking bench for the frame builder
`timescale 1ns/1ps
`default_nettype none
module tb_stack_frame_builder;
  typedef struct {
    logic [31:0] fb;
    logic [15:0] st;
    logic [4:0]  lv;
    logic [31:0] xsp;
  } sfb_row_type;
  logic ref_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, load_en = 1'b0, base_is_fb = 1'b0;
  logic cmd_ready, cmd_done, mem_ack;
  logic [1:0] default_seg, dly = 2'h0;
  logic [31:0] load_sp = 32'h0, load_fb = 32'h0, sp, fb, mem_rdata;
  sfb_pkg::sfb_cmd_type cmd = '0;
  sfb_pkg::sfb_mem_req_type mem_req;
  int n_errors = 0, compares = 0;
  sfb_row_type rows [5] = '{
    '{32'h380, 16'h0008, 5'h00, 32'h2F4}, '{32'h380, 16'h0010, 5'h01, 32'h2E8},
    '{32'h3C0, 16'h0000, 5'h02, 32'h2F4}, '{32'h3F0, 16'h0800, 5'h03, 32'hFFFF_FAF0},
    '{32'h3FC, 16'h0004, 5'h1F, 32'h27C}};
  always #5 ref_clk = ~ref_clk;
  sfb_frame_builder u_dut (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .load_en(load_en), .load_sp(load_sp),
    .load_fb(load_fb), .stack_pointer_reg(sp), .frame_base_pointer(fb),
    .base_is_fb(base_is_fb), .default_seg(default_seg), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  sfb_stack_mem u_mem (.ref_clk(ref_clk), .rstn(rstn), .dly(dly), .req(mem_req),
    .ack(mem_ack), .rdata(mem_rdata));
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick();
    @(posedge ref_clk);
    #1;
  endtask
  task summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task issue(input sfb_pkg::sfb_op_type op, input logic [15:0] st, input logic [4:0] lv);
    int k;
    cmd = '{op: op, storage: st, level: lv};
    cmd_valid = 1'b1;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    chk(32'(cmd_ready), 32'h1, "cmd_ready");
    tick();
    cmd_valid = 1'b0;
    k = 0;
    while (cmd_done !== 1'b1 && k < 2000) begin
      tick();
      k++;
    end
    chk(32'(cmd_done), 32'h1, "cmd_done");
  endtask
  initial begin
    #500000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (10) tick();
    chk(sp, sfb_pkg::SP_RESET, "reset sp");
    chk(fb, sfb_pkg::FB_RESET, "reset fb");
    chk(32'(cmd_done), 32'h0, "reset done");
    chk(32'(mem_req.valid), 32'h0, "reset req");
    $display("test reset done");
    rstn = 1'b1;
    foreach (rows[i]) begin
      dly = 2'(i % 3);
      load_en = 1'b1;
      load_sp = 32'h300;
      load_fb = rows[i].fb;
      tick();
      load_en = 1'b0;
      issue(sfb_pkg::SFB_OP_ENTER, rows[i].st, rows[i].lv);
      chk(sp, rows[i].xsp, "enter sp");
      chk(fb, 32'h2FC, "enter fb");
      chk(u_mem.mem[8'hBF], rows[i].fb, "saved base");
      if (rows[i].lv != 0) chk(u_mem.mem[(rows[i].xsp + rows[i].st) >> 2], 32'h2FC, "top");
      if (rows[i].lv > 1) chk(u_mem.mem[8'hBE], 32'hA500_0000 | ((rows[i].fb - 4) >> 2), "copy");
      issue(sfb_pkg::SFB_OP_LEAVE, 16'h0, 5'h0);
      chk(sp, 32'h300, "leave sp");
      chk(fb, rows[i].fb, "leave fb");
      $display("test %0d done", i);
    end
    base_is_fb = 1'b1;
    tick();
    chk(32'(default_seg), 32'(sfb_pkg::SEG_STACK), "seg stack");
    base_is_fb = 1'b0;
    tick();
    chk(32'(default_seg), 32'(sfb_pkg::SEG_DATA), "seg data");
    $display("test seg done");
    cmd = '{op: sfb_pkg::SFB_OP_NONE, storage: 16'h0010, level: 5'h01};
    cmd_valid = 1'b1;
    repeat (4) tick();
    cmd_valid = 1'b0;
    chk(sp, 32'h300, "none sp");
    chk(32'(cmd_ready), 32'h1, "none ready");
    chk(32'(cmd_done), 32'h0, "none done");
    $display("test none done");
    load_en = 1'b1;
    load_sp = 32'h300;
    load_fb = 32'h3FC;
    tick();
    load_en = 1'b0;
    cmd = '{op: sfb_pkg::SFB_OP_ENTER, storage: 16'h0004, level: 5'h1F};
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    repeat (20) tick();
    rstn = 1'b0;
    tick();
    chk(sp, sfb_pkg::SP_RESET, "midrun sp");
    chk(fb, sfb_pkg::FB_RESET, "midrun fb");
    chk(32'(mem_req.valid), 32'h0, "midrun req");
    chk(32'(cmd_ready), 32'h1, "midrun ready");
    rstn = 1'b1;
    issue(sfb_pkg::SFB_OP_ENTER, 16'h0008, 5'h00);
    chk(sp, 32'hFFFF_FFF4, "after reset sp");
    chk(fb, 32'hFFFF_FFFC, "after reset fb");
    chk(u_mem.mem[8'hFF], 32'h0000_0000, "after reset base");
    $display("test midrun reset done");
    summarize();
  end
endmodule
`default_nettype wire
